// >>> hdl/reload_timer_cfg.svh
`ifndef RELOAD_TIMER_CFG_SVH
`define RELOAD_TIMER_CFG_SVH
// register byte offsets, channel n at base + n * stride
`define RT_OFF_CTRL0    12'h000
`define RT_OFF_RELOAD0  12'h004
`define RT_OFF_COUNT0   12'h008
`define RT_CH_STRIDE    12'h010
`define RT_OFF_STATUS   12'h020
`define RT_OFF_MASK     12'h024
// control field positions
`define RT_CTRL_EN      0
`define RT_CTRL_START   1
`define RT_CTRL_RELOAD  2
`define RT_CTRL_SRC     3
`define RT_CTRL_CSEL_LO 4
`define RT_CTRL_EDGE_LO 6
`define RT_CTRL_XFER    8
// reset values
`define RT_CTRL_RST     32'h0000_0000
`define RT_RELOAD_RST   16'hffff
// prescaler taps: internal rates are clk/2, clk/8, clk/32
`define RT_DIV_W        5
`define RT_TAP0         1
`define RT_TAP1         3
`define RT_TAP2         5
`endif

// >>> hdl/reload_timer_pkg.sv
package reload_timer_pkg;
  typedef enum logic [1:0] {
    CS_DIV2  = 2'h0,
    CS_DIV8  = 2'h1,
    CS_DIV32 = 2'h2
  } clk_sel_t;
  typedef enum logic [1:0] {
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_sel_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOAD = 2'h1,
    ST_RUN  = 2'h3
  } ch_state_t;
  typedef struct packed {
    logic      xfer;
    edge_sel_t edge_sel;
    clk_sel_t  clk_sel;
    logic      src_ext;
    logic      reload_mode;
    logic      en;
  } ch_cfg_t;
  typedef struct packed {
    logic        paddr_ok;
    logic [11:0] paddr;
  } unused_t;
endpackage

// >>> hdl/reload_channel.sv
`timescale 1ns/10ps
`include "reload_timer_cfg.svh"
module reload_channel (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire reload_timer_pkg::ch_cfg_t cfg,
  input  wire logic                      start,
  input  wire logic [15:0]               reload_val,
  input  wire logic [2:0]                tick,
  input  wire logic                      ext_sync,
  output logic [15:0]                    count_q,
  output logic                           running_q,
  output logic                           uflow_q
);
  reload_timer_pkg::ch_state_t state_q;
  logic                        ext_prev_q;
  logic                        rise;
  logic                        fall;
  logic                        ev;
  logic                        int_ev;
  logic                        ext_ev;

  assign rise = ext_sync & ~ext_prev_q;
  assign fall = ~ext_sync & ext_prev_q;
  // three internal rates, one selected
  assign int_ev = (cfg.clk_sel == reload_timer_pkg::CS_DIV32) ? tick[2] :
                  (cfg.clk_sel == reload_timer_pkg::CS_DIV8)  ? tick[1] :
                  tick[0];
  assign ext_ev = (cfg.edge_sel[0] & rise) | (cfg.edge_sel[1] & fall);
  // one source at a time
  assign ev = cfg.src_ext ? ext_ev : int_ev;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_sync;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q   <= reload_timer_pkg::ST_IDLE;
      count_q   <= 16'h0000;
      running_q <= 1'b0;
      uflow_q   <= 1'b0;
    end else begin
      uflow_q <= 1'b0;
      case (state_q)
        reload_timer_pkg::ST_IDLE: begin
          running_q <= 1'b0;
          if (start && cfg.en) begin
            state_q <= reload_timer_pkg::ST_LOAD;
          end
        end
        reload_timer_pkg::ST_LOAD: begin
          count_q   <= reload_val;
          running_q <= 1'b1;
          state_q   <= reload_timer_pkg::ST_RUN;
        end
        reload_timer_pkg::ST_RUN: begin
          if (!cfg.en) begin
            state_q   <= reload_timer_pkg::ST_IDLE;
            running_q <= 1'b0;
          end else if (start) begin
            state_q <= reload_timer_pkg::ST_LOAD;
          end else if (ev) begin
            if (count_q == 16'h0000) begin
              uflow_q <= 1'b1;
              if (cfg.reload_mode) begin
                count_q <= reload_val;
              end else begin
                count_q   <= 16'hffff;
                running_q <= 1'b0;
                state_q   <= reload_timer_pkg::ST_IDLE;
              end
            end else begin
              count_q <= count_q - 16'h0001;
            end
          end
        end
        default: begin
          state_q <= reload_timer_pkg::ST_IDLE;
        end
      endcase
    end
  end

  a_uflow_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    uflow_q |-> $past(count_q) == 16'h0000)
    else $error("underflow without zero count");
  a_reload_after: assert property (@(posedge ref_clk) disable iff (!rst_n)
    uflow_q && cfg.reload_mode && $past(cfg.reload_mode)
      && $past(state_q) == reload_timer_pkg::ST_RUN
    |-> count_q == $past(reload_val))
    else $error("reload not applied on underflow");
  a_oneshot_halt: assert property (@(posedge ref_clk) disable iff (!rst_n)
    uflow_q && !$past(cfg.reload_mode) |-> !running_q)
    else $error("one-shot did not stop");
  a_start_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == reload_timer_pkg::ST_LOAD ##1 1'b1
    |-> count_q == $past(reload_val))
    else $error("start did not load reload value");
  a_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == reload_timer_pkg::ST_RUN && cfg.en && !start && ev
      && count_q != 16'h0000
    |=> count_q == $past(count_q) - 16'h0001)
    else $error("counter did not step down by one");
  a_hold_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == reload_timer_pkg::ST_RUN && !ev && !start && cfg.en
    |=> $stable(count_q))
    else $error("count moved without a count event");
endmodule // reload_channel

// >>> hdl/reload_timer.sv
`timescale 1ns/10ps
`include "reload_timer_cfg.svh"
// Behaviour
// - each channel holds a 16-bit counter stepping down one per event
// - internal mode counts on one of three divided clocks
// - event mode counts on the chosen edge of the event pin
// - each channel uses exactly one source, internal or external
// - underflow is the event taken at 0000 (one-shot goes to ffff, reload mode to reload value), not reaching zero
// - period is reload value plus one counts
// - reload mode copies reload value on underflow and keeps counting
// - one-shot mode halts after first underflow until restarted
// - an underflow can raise an interrupt request
// - underflow can trigger the data-transfer service instead
// - two independent channels with own settings and requests
module reload_timer (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  event_in,
  output logic             irq,
  output logic [1:0]       xfer_req
);
  localparam int NCH = 2;

  logic [`RT_DIV_W-1:0]        div_q;
  logic [`RT_DIV_W-1:0]        div_d;
  logic [2:0]                  tick_q;
  logic [1:0]                  ev_meta_q;
  logic [1:0]                  ev_sync_q;
  reload_timer_pkg::ch_cfg_t   cfg_q [NCH];
  logic [15:0]                 reload_q [NCH];
  logic [NCH-1:0]              start_q;
  logic [NCH-1:0]              status_q;
  logic [NCH-1:0]              mask_q;
  logic [15:0]                 count_w [NCH];
  logic [NCH-1:0]              running_w;
  logic [NCH-1:0]              uflow_w;
  logic                        wr_en;
  logic                        rd_en;
  logic                        hit;
  logic [31:0]                 rd_d;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  // prescaler for the three internal rates
  assign div_d = div_q + `RT_DIV_W'(1);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_q  <= '0;
      tick_q <= 3'h0;
    end else begin
      div_q     <= div_d;
      tick_q[0] <= (div_d[`RT_TAP0-1:0] == '0);
      tick_q[1] <= (div_d[`RT_TAP1-1:0] == '0);
      tick_q[2] <= (div_d[`RT_TAP2-1:0] == '0);
    end
  end

  // event pins synchronised
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ev_meta_q <= 2'h0;
      ev_sync_q <= 2'h0;
    end else begin
      ev_meta_q <= event_in;
      ev_sync_q <= ev_meta_q;
    end
  end

  // two channel instances
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      reload_channel u_ch (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .cfg        (cfg_q[g]),
        .start      (start_q[g]),
        .reload_val (reload_q[g]),
        .tick       (tick_q),
        .ext_sync   (ev_sync_q[g]),
        .count_q    (count_w[g]),
        .running_q  (running_w[g]),
        .uflow_q    (uflow_w[g])
      );
    end
  endgenerate

  // control and reload registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        cfg_q[i]    <= reload_timer_pkg::ch_cfg_t'(`RT_CTRL_RST);
        reload_q[i] <= `RT_RELOAD_RST;
      end
      start_q <= '0;
      mask_q  <= '0;
    end else begin
      start_q <= '0;
      if (wr_en) begin
        for (int i = 0; i < NCH; i++) begin
          if (paddr == `RT_OFF_CTRL0 + 12'(i) * `RT_CH_STRIDE) begin
            cfg_q[i].en          <= pwdata[`RT_CTRL_EN];
            cfg_q[i].reload_mode <= pwdata[`RT_CTRL_RELOAD];
            cfg_q[i].src_ext     <= pwdata[`RT_CTRL_SRC];
            cfg_q[i].clk_sel     <= reload_timer_pkg::clk_sel_t'(
              pwdata[`RT_CTRL_CSEL_LO +: 2]);
            cfg_q[i].edge_sel    <= reload_timer_pkg::edge_sel_t'(
              pwdata[`RT_CTRL_EDGE_LO +: 2]);
            cfg_q[i].xfer        <= pwdata[`RT_CTRL_XFER];
            start_q[i]           <= pwdata[`RT_CTRL_START]
                                    & pwdata[`RT_CTRL_EN];
          end
          if (paddr == `RT_OFF_RELOAD0 + 12'(i) * `RT_CH_STRIDE) begin
            reload_q[i] <= pwdata[15:0];
          end
        end
        if (paddr == `RT_OFF_MASK) begin
          mask_q <= pwdata[NCH-1:0];
        end
      end
    end
  end

  // sticky underflow flags, set wins over write-one-clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (uflow_w[i] && !cfg_q[i].xfer) begin
          status_q[i] <= 1'b1;
        end else if (wr_en && paddr == `RT_OFF_STATUS && pwdata[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  end

  // interrupt and transfer requests
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq      <= 1'b0;
      xfer_req <= 2'h0;
    end else begin
      irq <= |(status_q & mask_q);
      for (int i = 0; i < NCH; i++) begin
        xfer_req[i] <= uflow_w[i] & cfg_q[i].xfer;
      end
    end
  end

  // read decode
  always_comb begin
    rd_d = 32'h0000_0000;
    hit  = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (paddr == `RT_OFF_CTRL0 + 12'(i) * `RT_CH_STRIDE) begin
        hit  = 1'b1;
        rd_d = {23'h0, cfg_q[i].xfer, cfg_q[i].edge_sel, cfg_q[i].clk_sel,
                cfg_q[i].src_ext, cfg_q[i].reload_mode, running_w[i],
                cfg_q[i].en};
      end
      if (paddr == `RT_OFF_RELOAD0 + 12'(i) * `RT_CH_STRIDE) begin
        hit  = 1'b1;
        rd_d = {16'h0, reload_q[i]};
      end
      if (paddr == `RT_OFF_COUNT0 + 12'(i) * `RT_CH_STRIDE) begin
        hit  = 1'b1;
        rd_d = {16'h0, count_w[i]};
      end
    end
    if (paddr == `RT_OFF_STATUS) begin
      hit  = 1'b1;
      rd_d = {30'h0, status_q};
    end
    if (paddr == `RT_OFF_MASK) begin
      hit  = 1'b1;
      rd_d = {30'h0, mask_q};
    end
  end

  // apb answer: one wait-free access phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (rd_en) begin
        prdata <= rd_d;
      end
    end
  end

  a_irq_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (status_q & mask_q) != '0 |=> irq)
    else $error("irq missing with unmasked flag");
  a_irq_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq |-> $past((status_q & mask_q) != '0))
    else $error("irq without unmasked flag");
  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    uflow_w[0] && !cfg_q[0].xfer |=> status_q[0])
    else $error("underflow flag not set");
  a_xfer_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    uflow_w[1] && cfg_q[1].xfer |=> xfer_req[1] && !$rose(status_q[1]))
    else $error("transfer request not routed");
  a_tick_rate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick_q[0] |=> !tick_q[0] ##1 tick_q[0])
    else $error("fast tick not every second cycle");
endmodule // reload_timer

// >>> tb/event_source.sv
`timescale 1ns/10ps
module event_source (
  input  wire logic  ref_clk,
  output logic [1:0] event_in
);
  // event pins idle low, each pulse outlasts the pin synchroniser
  initial event_in = 2'h0;

  task automatic pulse(input int ch);
    @(posedge ref_clk);
    event_in[ch] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    event_in[ch] <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule // event_source

// >>> tb/tb_reload_timer.sv
`timescale 1ns/10ps
`include "reload_timer_cfg.svh"
module tb_reload_timer;
  logic        ref_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  event_in;
  logic        irq;
  logic [1:0]  xfer_req;
  int          failures;
  int          check_count;
  int          xfer_cnt;
  int          xfer0_cnt;
  logic [31:0] r;
  logic        e;
  int          n;

  reload_timer i_reload_timer (
    .ref_clk (ref_clk), .rst_n (rst_n), .psel (psel),
    .penable (penable), .pwrite (pwrite), .paddr (paddr),
    .pwdata (pwdata), .prdata (prdata), .pready (pready),
    .pslverr (pslverr), .event_in (event_in), .irq (irq),
    .xfer_req (xfer_req)
  );
  event_source i_event_source (.ref_clk (ref_clk), .event_in (event_in));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // xfer request pulses of channel 1, and any cycle where channel 0's request is not low
  always @(posedge ref_clk) begin
    if (xfer_req[1] === 1'b1) xfer_cnt++;
    if (xfer_req[0] !== 1'b0) xfer0_cnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) failures++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_irq(input logic lvl);
    n = 0;
    while (irq !== lvl && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    failures++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    failures = 0;
    check_count = 0;
    xfer_cnt = 0;
    xfer0_cnt = 0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, `RT_OFF_CTRL0, 32'h0);
    check(r, `RT_CTRL_RST);
    apb(1'b0, `RT_OFF_RELOAD0 + `RT_CH_STRIDE, 32'h0);
    check(r, {16'h0000, `RT_RELOAD_RST});
    apb(1'b0, 12'h0fc, 32'h0);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    // internal clocks: 4 ticks of clk/2, clk/8, clk/32
    apb(1'b1, `RT_OFF_MASK, 32'h1);
    apb(1'b1, `RT_OFF_RELOAD0, 32'h3);
    for (int cs = 0; cs < 3; cs++) begin
      apb(1'b1, `RT_OFF_CTRL0, 32'h3 | (cs << `RT_CTRL_CSEL_LO));
      wait_irq(1'b1);
      check(irq, 1'b1);
      check(n >= 3 * (2 << (2 * cs)) - 4, 1'b1);
      check(n <= 4 * (2 << (2 * cs)) + 8, 1'b1);
      apb(1'b0, `RT_OFF_COUNT0, 32'h0);
      check(r, 32'h0000_ffff);
      apb(1'b0, `RT_OFF_CTRL0, 32'h0);
      check(r[1], 1'b0);
      apb(1'b1, `RT_OFF_MASK, 32'h0);
      repeat (3) @(posedge ref_clk);
      check(irq, 1'b0);
      apb(1'b0, `RT_OFF_STATUS, 32'h0);
      check(r, 32'h1);
      apb(1'b1, `RT_OFF_STATUS, 32'h1);
      apb(1'b0, `RT_OFF_STATUS, 32'h0);
      check(r, 32'h0);
      apb(1'b1, `RT_OFF_MASK, 32'h1);
    end
    // channel 1: rising edges, reload mode, transfer request
    apb(1'b1, `RT_OFF_RELOAD0 + `RT_CH_STRIDE, 32'h2);
    apb(1'b1, `RT_OFF_CTRL0 + `RT_CH_STRIDE, 32'h0000_014f);
    repeat (4) @(posedge ref_clk);
    apb(1'b0, `RT_OFF_COUNT0 + `RT_CH_STRIDE, 32'h0);
    check(r, 32'h2);
    for (int k = 1; k >= 0; k--) begin
      i_event_source.pulse(1);
      apb(1'b0, `RT_OFF_COUNT0 + `RT_CH_STRIDE, 32'h0);
      check(r, k);
      check(xfer_cnt, 0);
    end
    repeat (100) @(posedge ref_clk);
    apb(1'b0, `RT_OFF_COUNT0 + `RT_CH_STRIDE, 32'h0);
    check(r, 32'h0);
    i_event_source.pulse(1);
    check(xfer_cnt, 1);
    apb(1'b0, `RT_OFF_COUNT0 + `RT_CH_STRIDE, 32'h0);
    check(r, 32'h2);
    apb(1'b0, `RT_OFF_STATUS, 32'h0);
    check(r, 32'h0);
    check(irq, 1'b0);
    // both edges: one pulse steps the counter twice
    apb(1'b1, `RT_OFF_CTRL0 + `RT_CH_STRIDE, 32'h0000_01cf);
    i_event_source.pulse(1);
    apb(1'b0, `RT_OFF_COUNT0 + `RT_CH_STRIDE, 32'h0);
    check(r, 32'h0);
    check(xfer_cnt, 1);
    check(xfer0_cnt, 0);
    apb(1'b0, `RT_OFF_COUNT0, 32'h0);
    check(r, 32'h0000_ffff);
    finish_test();
  end
endmodule // tb_reload_timer
